// [hw/pcuel_pkg.sv]
// Constants and types for the uncorrectable error status and mask bank
package pcuel_pkg;

    // Byte offsets of the three registers
    localparam logic [11:0] PCUEL_OFS_NEXT_CAP  = 12'h100;
    localparam logic [11:0] PCUEL_OFS_STATUS    = 12'h104;
    localparam logic [11:0] PCUEL_OFS_MASK      = 12'h108;

    // Next capability link word fields
    localparam int          PCUEL_NEXT_PTR_LSB  = 20;
    localparam logic [11:0] PCUEL_NEXT_PTR_UP   = 12'h140;
    localparam logic [11:0] PCUEL_NEXT_PTR_DN   = 12'h20C;
    localparam int          PCUEL_CAP_VER_LSB   = 16;
    localparam logic [3:0]  PCUEL_CAP_VERSION   = 4'h1;
    localparam logic [15:0] PCUEL_CAP_ID        = 16'h0001;

    // Edges the strap spends in its synchroniser before capture
    localparam logic [1:0]  PCUEL_STRAP_SETTLE  = 2'h2;

    // Error class bit positions in status and mask
    localparam int PCUEL_BIT_TRAIN    = 0;
    localparam int PCUEL_BIT_DLPROT   = 4;
    localparam int PCUEL_BIT_POISON   = 12;
    localparam int PCUEL_BIT_FCPROT   = 13;
    localparam int PCUEL_BIT_CPL_TO   = 14;
    localparam int PCUEL_BIT_CPL_ABRT = 15;
    localparam int PCUEL_BIT_UNEXP    = 16;
    localparam int PCUEL_BIT_RX_OVF   = 17;
    localparam int PCUEL_BIT_MALF     = 18;
    localparam int PCUEL_BIT_ECRC     = 19;
    localparam int PCUEL_BIT_UNSUP    = 20;
    localparam int PCUEL_EVENT_W      = 21;

    // Implemented bits; all others read as zero
    localparam logic [31:0] PCUEL_VALID_BITS    = 32'h001F_F011;
    localparam logic [31:0] PCUEL_STATUS_RESET  = 32'h0000_0000;
    localparam logic [31:0] PCUEL_MASK_RESET    = 32'h0000_0000;

    // AHB-Lite encodings
    localparam logic [1:0]  PCUEL_HRESP_OKAY    = 2'h0;

    // Write target latched in the address phase
    typedef enum logic [1:0] {
        PCUEL_SEL_NONE   = 2'b00,
        PCUEL_SEL_STATUS = 2'b01,
        PCUEL_SEL_MASK   = 2'b10,
        PCUEL_SEL_NEXT   = 2'b11
    } pcuel_sel_t;

    // Bus phase
    typedef enum logic {
        PCUEL_PH_IDLE  = 1'b0,
        PCUEL_PH_WRITE = 1'b1
    } pcuel_phase_t;

endpackage

// [hw/pcuel_top.sv]
// Uncorrectable error status and report mask bank with AHB-Lite access
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Bits 31:20 of next link word read-only: 140h upstream, 20Ch downstream.
// - Status bit 0 sets on link training error, resets zero, write-one clears.
// - Status bit 4 sets on data link protocol error, write-one clears.
// - Status bit 12 sets on poisoned packet received or generated, write-one clears.
// - Status bit 13 sets on flow control protocol error, write-one clears.
// - Status bit 14 sets on completion timeout, write-one clears.
// - Status bit 15 sets on completer abort, write-one clears.
// - Status bit 16 sets on unexpected completion, write-one clears.
// - Status bit 17 sets on receiver overflow, write-one clears.
// - Status bit 18 sets on malformed packet, write-one clears.
// - Status bit 19 sets on end-to-end CRC failure, write-one clears.
// - Status bit 20 sets on unsupported request; unused bits read zero.
// - Mask bits 0 and 4 block reporting of their errors; status still logs them.
// - Mask bit 12 blocks reporting of poisoned packets; status still logs them.
// - Mask bit 13 blocks reporting of flow control errors; status still logs them.
// - Mask bit 14 blocks reporting of completion timeouts; status still logs them.
// - Mask bit 15 blocks reporting of completer aborts; status still logs them.
// - Mask bit 16 blocks reporting of unexpected completions; status still logs them.
// - Mask bit 17 blocks reporting of receiver overflows; status still logs them.
// - Mask bit 18 blocks reporting of malformed packets; status still logs them.
// - Mask bit 19 blocks reporting of CRC failures; status still logs them.
// - Mask bit 20 blocks unsupported request reporting; masks reset to zero.
module pcuel_top
    import pcuel_pkg::*;
(
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hot_reset,
    input  wire logic                      port_is_downstream,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic [1:0]                     hresp,
    output logic [31:0]                    hrdata,
    input  wire logic [PCUEL_EVENT_W-1:0]  err_event,
    output logic [PCUEL_EVENT_W-1:0]       err_report,
    output logic [PCUEL_EVENT_W-1:0]       err_status,
    output logic                           port_is_downstream_reg
);

    // All state of the bank
    typedef struct packed {
        pcuel_phase_t phase;
        pcuel_sel_t   wsel;
        logic         strap_meta;
        logic         strap_sync;
        logic [1:0]   strap_age;
        logic         strap_done;
        logic         port_ds;
        logic         ready;
        logic [31:0]  status;
        logic [31:0]  mask;
        logic [31:0]  rdata;
        logic [31:0]  report;
    } pcuel_state_t;

    pcuel_state_t st_reg;
    pcuel_state_t st_next;

    logic [31:0] ev_word;
    logic [31:0] wr_clear;
    logic        take;

    // Address decode of the low twelve address bits
    function automatic pcuel_sel_t pcuel_decode(input logic [31:0] addr);
        pcuel_sel_t sel;
        sel = PCUEL_SEL_NONE;
        case (addr[11:0])
            PCUEL_OFS_NEXT_CAP: sel = PCUEL_SEL_NEXT;
            PCUEL_OFS_STATUS:   sel = PCUEL_SEL_STATUS;
            PCUEL_OFS_MASK:     sel = PCUEL_SEL_MASK;
            default:            sel = PCUEL_SEL_NONE;
        endcase
        return sel;
    endfunction

    // Event pulses widened to register layout, reserved positions dropped
    assign ev_word  = {11'h000, err_event} & PCUEL_VALID_BITS;
    assign take     = hsel & htrans[1] & hready;
    assign wr_clear = (st_reg.phase == PCUEL_PH_WRITE && st_reg.wsel == PCUEL_SEL_STATUS)
                    ? (hwdata & PCUEL_VALID_BITS) : 32'h0000_0000;

    // Next state of the bank
    always_comb begin
        st_next       = st_reg;
        st_next.ready = 1'b1;
        // Strap pin passes two flip-flops, then is caught once
        st_next.strap_meta = port_is_downstream;
        st_next.strap_sync = st_reg.strap_meta;
        if (!st_reg.strap_done) begin
            if (st_reg.strap_age == PCUEL_STRAP_SETTLE) begin
                st_next.port_ds    = st_reg.strap_sync;
                st_next.strap_done = 1'b1;
            end else begin
                st_next.strap_age = st_reg.strap_age + 2'h1;
            end
        end
        // Set beats clear in the same cycle
        st_next.status = (st_reg.status & ~wr_clear) | ev_word;
        // Mask write lands in the data phase
        if (st_reg.phase == PCUEL_PH_WRITE && st_reg.wsel == PCUEL_SEL_MASK) begin
            st_next.mask = hwdata & PCUEL_VALID_BITS;
        end
        // Only unmasked events reach messaging; status logs every event
        st_next.report = ev_word & ~st_reg.mask;
        // Bus address phase
        st_next.phase = PCUEL_PH_IDLE;
        st_next.wsel  = PCUEL_SEL_NONE;
        if (take) begin
            if (hwrite) begin
                st_next.phase = PCUEL_PH_WRITE;
                st_next.wsel  = pcuel_decode(haddr);
            end else begin
                case (pcuel_decode(haddr))
                    PCUEL_SEL_NEXT: begin
                        st_next.rdata = 32'h0000_0000;
                        st_next.rdata[31:PCUEL_NEXT_PTR_LSB] = st_reg.port_ds
                            ? PCUEL_NEXT_PTR_DN : PCUEL_NEXT_PTR_UP;
                        st_next.rdata[PCUEL_NEXT_PTR_LSB-1:PCUEL_CAP_VER_LSB] =
                            PCUEL_CAP_VERSION;
                        st_next.rdata[15:0] = PCUEL_CAP_ID;
                    end
                    PCUEL_SEL_STATUS: st_next.rdata = st_next.status & PCUEL_VALID_BITS;
                    PCUEL_SEL_MASK:   st_next.rdata = st_next.mask & PCUEL_VALID_BITS;
                    default:          st_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Hot reset clears bus state but keeps sticky bits
        if (hot_reset) begin
            st_next.phase  = PCUEL_PH_IDLE;
            st_next.wsel   = PCUEL_SEL_NONE;
            st_next.rdata  = 32'h0000_0000;
            st_next.report = 32'h0000_0000;
            st_next.status = st_reg.status | ev_word;
            st_next.mask   = st_reg.mask;
        end
    end

    // State register, power-on reset only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg            <= '0;
            st_reg.ready      <= 1'b1;
            st_reg.status     <= PCUEL_STATUS_RESET;
            st_reg.mask       <= PCUEL_MASK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register, hresp tied to OKAY
    assign hreadyout              = st_reg.ready;
    assign hresp                  = PCUEL_HRESP_OKAY;
    assign hrdata                 = st_reg.rdata;
    assign err_report             = st_reg.report[PCUEL_EVENT_W-1:0];
    assign err_status             = st_reg.status[PCUEL_EVENT_W-1:0];
    assign port_is_downstream_reg = st_reg.port_ds;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Status bits follow their events
    a_status_sets_event: assert property (
        (ev_word != 32'h0000_0000) |=> ((st_reg.status & $past(ev_word)) == $past(ev_word)))
        else $error("status bit not set by event");

    // Write one clears a bit with no fresh event
    a_status_w1c_clear: assert property (
        (wr_clear != 32'h0000_0000 && !hot_reset)
        |=> ((st_reg.status & $past(wr_clear) & ~$past(ev_word)) == 32'h0000_0000))
        else $error("write one did not clear status");

    // Status bits never drop without a clear
    a_status_no_drop: assert property (
        (wr_clear == 32'h0000_0000) |=> ((st_reg.status & $past(st_reg.status))
        == $past(st_reg.status)))
        else $error("status bit lost without clear");

    // Reserved bits stay zero
    a_reserved_zero: assert property (
        ((st_reg.status | st_reg.mask) & ~PCUEL_VALID_BITS) == 32'h0000_0000)
        else $error("reserved bit set");

    // Report tracks unmasked events one cycle later
    a_report_masked: assert property (
        !hot_reset |=> (st_reg.report == ($past(ev_word) & ~$past(st_reg.mask))))
        else $error("report ignores mask");

    // Mask write takes effect
    a_mask_write: assert property (
        (st_reg.phase == PCUEL_PH_WRITE && st_reg.wsel == PCUEL_SEL_MASK && !hot_reset)
        |=> (st_reg.mask == ($past(hwdata) & PCUEL_VALID_BITS)))
        else $error("mask write lost");

    // Sticky bits survive hot reset
    a_hot_sticky: assert property (
        hot_reset |=> (st_reg.status == ($past(st_reg.status) | $past(ev_word))
                       && st_reg.mask == $past(st_reg.mask)))
        else $error("sticky bits changed by hot reset");

    // Pointer read answers per port type
    a_next_ptr_read: assert property (
        (take && !hwrite && !hot_reset && haddr[11:0] == PCUEL_OFS_NEXT_CAP && st_reg.strap_done)
        |=> (hrdata[31:PCUEL_NEXT_PTR_LSB] == (st_reg.port_ds ? PCUEL_NEXT_PTR_DN
                                                               : PCUEL_NEXT_PTR_UP)))
        else $error("next pointer value wrong");

    // Captured port type holds once caught
    a_strap_hold: assert property (
        st_reg.strap_done |=> $stable(st_reg.port_ds))
        else $error("port type changed after capture");

    // Training error sets its flag
    a_train_sets: assert property (
        err_event[PCUEL_BIT_TRAIN] |=> err_status[PCUEL_BIT_TRAIN])
        else $error("training error flag not set");

    // Link protocol error sets its flag
    a_dlprot_sets: assert property (
        err_event[PCUEL_BIT_DLPROT] |=> err_status[PCUEL_BIT_DLPROT])
        else $error("link protocol error flag not set");

    // Poisoned packet sets its flag
    a_poison_sets: assert property (
        err_event[PCUEL_BIT_POISON] |=> err_status[PCUEL_BIT_POISON])
        else $error("poisoned packet flag not set");

    // Flow control error sets its flag
    a_fcprot_sets: assert property (
        err_event[PCUEL_BIT_FCPROT] |=> err_status[PCUEL_BIT_FCPROT])
        else $error("flow control error flag not set");

    // Completion timeout sets its flag
    a_cpl_to_sets: assert property (
        err_event[PCUEL_BIT_CPL_TO] |=> err_status[PCUEL_BIT_CPL_TO])
        else $error("completion timeout flag not set");

    // Completer abort sets its flag
    a_cpl_abrt_sets: assert property (
        err_event[PCUEL_BIT_CPL_ABRT] |=> err_status[PCUEL_BIT_CPL_ABRT])
        else $error("completer abort flag not set");

    // Unexpected completion sets its flag
    a_unexp_sets: assert property (
        err_event[PCUEL_BIT_UNEXP] |=> err_status[PCUEL_BIT_UNEXP])
        else $error("unexpected completion flag not set");

    // Receiver overflow sets its flag
    a_rx_ovf_sets: assert property (
        err_event[PCUEL_BIT_RX_OVF] |=> err_status[PCUEL_BIT_RX_OVF])
        else $error("receiver overflow flag not set");

    // Malformed packet sets its flag
    a_malf_sets: assert property (
        err_event[PCUEL_BIT_MALF] |=> err_status[PCUEL_BIT_MALF])
        else $error("malformed packet flag not set");

    // End-to-end CRC failure sets its flag
    a_crc_sets: assert property (
        err_event[PCUEL_BIT_ECRC] |=> err_status[PCUEL_BIT_ECRC])
        else $error("CRC failure flag not set");

    // Unsupported request sets its flag
    a_unsup_sets: assert property (
        err_event[PCUEL_BIT_UNSUP] |=> err_status[PCUEL_BIT_UNSUP])
        else $error("unsupported request flag not set");

    // Training error reported only while unmasked
    a_train_report: assert property (
        (err_event[PCUEL_BIT_TRAIN] && !hot_reset)
        |=> (err_report[PCUEL_BIT_TRAIN] == !$past(st_reg.mask[PCUEL_BIT_TRAIN])))
        else $error("training error report wrong");

    // Link protocol error reported only while unmasked
    a_dlprot_report: assert property (
        (err_event[PCUEL_BIT_DLPROT] && !hot_reset)
        |=> (err_report[PCUEL_BIT_DLPROT] == !$past(st_reg.mask[PCUEL_BIT_DLPROT])))
        else $error("link protocol error report wrong");

    // Poisoned packet reported only while unmasked
    a_poison_report: assert property (
        (err_event[PCUEL_BIT_POISON] && !hot_reset)
        |=> (err_report[PCUEL_BIT_POISON] == !$past(st_reg.mask[PCUEL_BIT_POISON])))
        else $error("poisoned packet report wrong");

    // Flow control error reported only while unmasked
    a_fcprot_report: assert property (
        (err_event[PCUEL_BIT_FCPROT] && !hot_reset)
        |=> (err_report[PCUEL_BIT_FCPROT] == !$past(st_reg.mask[PCUEL_BIT_FCPROT])))
        else $error("flow control error report wrong");

    // Completion timeout reported only while unmasked
    a_cpl_to_report: assert property (
        (err_event[PCUEL_BIT_CPL_TO] && !hot_reset)
        |=> (err_report[PCUEL_BIT_CPL_TO] == !$past(st_reg.mask[PCUEL_BIT_CPL_TO])))
        else $error("completion timeout report wrong");

    // Completer abort reported only while unmasked
    a_cpl_abrt_report: assert property (
        (err_event[PCUEL_BIT_CPL_ABRT] && !hot_reset)
        |=> (err_report[PCUEL_BIT_CPL_ABRT] == !$past(st_reg.mask[PCUEL_BIT_CPL_ABRT])))
        else $error("completer abort report wrong");

    // Unexpected completion reported only while unmasked
    a_unexp_report: assert property (
        (err_event[PCUEL_BIT_UNEXP] && !hot_reset)
        |=> (err_report[PCUEL_BIT_UNEXP] == !$past(st_reg.mask[PCUEL_BIT_UNEXP])))
        else $error("unexpected completion report wrong");

    // Receiver overflow reported only while unmasked
    a_rx_ovf_report: assert property (
        (err_event[PCUEL_BIT_RX_OVF] && !hot_reset)
        |=> (err_report[PCUEL_BIT_RX_OVF] == !$past(st_reg.mask[PCUEL_BIT_RX_OVF])))
        else $error("receiver overflow report wrong");

    // Malformed packet reported only while unmasked
    a_malf_report: assert property (
        (err_event[PCUEL_BIT_MALF] && !hot_reset)
        |=> (err_report[PCUEL_BIT_MALF] == !$past(st_reg.mask[PCUEL_BIT_MALF])))
        else $error("malformed packet report wrong");

    // CRC failure reported only while unmasked
    a_crc_report: assert property (
        (err_event[PCUEL_BIT_ECRC] && !hot_reset)
        |=> (err_report[PCUEL_BIT_ECRC] == !$past(st_reg.mask[PCUEL_BIT_ECRC])))
        else $error("CRC failure report wrong");

    // Unsupported request reported only while unmasked
    a_unsup_report: assert property (
        (err_event[PCUEL_BIT_UNSUP] && !hot_reset)
        |=> (err_report[PCUEL_BIT_UNSUP] == !$past(st_reg.mask[PCUEL_BIT_UNSUP])))
        else $error("unsupported request report wrong");

    // Status read shows fresh events and zero reserved bits
    a_status_read: assert property (
        (take && !hwrite && !hot_reset && haddr[11:0] == PCUEL_OFS_STATUS)
        |=> ((hrdata & ~PCUEL_VALID_BITS) == 32'h0000_0000
             && (hrdata & $past(ev_word)) == $past(ev_word)))
        else $error("status read data wrong");

    // Mask read returns the held mask
    a_mask_read: assert property (
        (take && !hwrite && !hot_reset && haddr[11:0] == PCUEL_OFS_MASK)
        |=> (hrdata == st_reg.mask))
        else $error("mask read data wrong");

    // Mask moves only by a mask write
    a_mask_no_drift: assert property (
        !(st_reg.phase == PCUEL_PH_WRITE && st_reg.wsel == PCUEL_SEL_MASK)
        |=> $stable(st_reg.mask))
        else $error("mask changed without write");

    // Hot reset silences report and read data
    a_hot_quiet: assert property (
        hot_reset |=> (err_report == 21'h00_0000 && hrdata == 32'h0000_0000))
        else $error("hot reset left report or read data");

    // Main scenarios
    c_strap_down:     cover property (st_reg.strap_done && st_reg.port_ds);
    c_masked_event:   cover property ((ev_word & st_reg.mask) != 32'h0000_0000);
    c_set_and_clear:  cover property ((ev_word & wr_clear) != 32'h0000_0000);
    c_hot_reset_hold: cover property (hot_reset && st_reg.status != 32'h0000_0000);
    c_status_read:    cover property (take && !hwrite && haddr[11:0] == PCUEL_OFS_STATUS);

endmodule
`default_nettype wire

// [tb/pcuel_rc_model.sv]
// Root complex side sink that tallies reported error events
`timescale 1ns/10ps
`default_nettype none
module pcuel_rc_model
    import pcuel_pkg::*;
(
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic [PCUEL_EVENT_W-1:0] err_report,
    output logic [31:0]                   msg_count
);
    // Each reported bit counts as one error message received
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msg_count <= 32'h0000_0000;
        end else begin
            msg_count <= msg_count + 32'($countones(err_report));
        end
    end
endmodule
`default_nettype wire

// [tb/pcuel_bench.sv]
// Register and event tests of the uncorrectable error bank
`timescale 1ns/10ps
`default_nettype none
module pcie_uncorrectable_error_log_bench
    import pcuel_pkg::*;
;
    logic        hclk, hresetn, hot_reset, port_is_downstream, hsel, hwrite, hreadyout;
    logic        strap_seen;
    logic [31:0] haddr, hwdata, hrdata, msg_count;
    logic [1:0]  htrans, hresp;
    logic [2:0]  hsize;
    logic [20:0] err_event, err_report, err_status;
    logic [31:0] next_up, next_dn, dummy;
    int          err_total, num_checks;
    assign next_up = {PCUEL_NEXT_PTR_UP, PCUEL_CAP_VERSION, PCUEL_CAP_ID};
    assign next_dn = {PCUEL_NEXT_PTR_DN, PCUEL_CAP_VERSION, PCUEL_CAP_ID};
    // Design under test, hready fed back from the single slave
    pcuel_top i_dut (.hclk(hclk), .hresetn(hresetn), .hot_reset(hot_reset),
        .port_is_downstream(port_is_downstream), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .err_event(err_event), .err_report(err_report), .err_status(err_status),
        .port_is_downstream_reg(strap_seen));
    // Far side receiving reported errors
    pcuel_rc_model i_rc (.hclk(hclk), .hresetn(hresetn), .err_report(err_report),
        .msg_count(msg_count));
    // Clock, 8 ns period
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single AHB-Lite transfer, waits on hready in both phases
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", {30'h0, PCUEL_HRESP_OKAY}, {30'h0, hresp});
    endtask
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        chk(what, exp, v);
    endtask
    // One-cycle event pulse, report checked the cycle after
    task automatic pulse(input logic [20:0] ev, input logic [20:0] exp_rep);
        @(posedge hclk);
        err_event <= ev;
        @(posedge hclk);
        err_event <= '0;
        #1;
        chk("err_report", {11'h0, exp_rep}, {11'h0, err_report});
    endtask
    task automatic do_reset(input logic strap);
        port_is_downstream <= strap;
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask
    // Watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge hclk);
        err_total++;
        finish_test();
    end
    // Main sequence
    initial begin
        {hresetn, hot_reset, port_is_downstream, hsel, hwrite} = 5'h00;
        {haddr, hwdata, htrans, hsize, err_event} = '0;
        err_total = 0;
        num_checks = 0;
        hsize <= 3'h2;
        do_reset(1'b0);
        rdchk("next_link", 12'h100, next_up);
        chk("strap", 32'h0, {31'h0, strap_seen});
        rdchk("status", 12'h104, 32'h0);
        rdchk("mask", 12'h108, 32'h0);
        rdchk("unmapped", 12'h10C, 32'h0);
        $display("test reset_values done");
        for (int i = 0; i < 21; i++) if (PCUEL_VALID_BITS[i]) pulse(21'(1 << i), 21'(1 << i));
        pulse(21'h00_0FEE, 21'h0);
        rdchk("status", 12'h104, PCUEL_VALID_BITS);
        chk("msg_count", 32'd11, msg_count);
        $display("test events done");
        bus(1'b1, 12'h100, 32'hFFFF_FFFF, dummy);
        rdchk("next_link", 12'h100, next_up);
        bus(1'b1, 12'h104, 32'h0000_0001, dummy);
        rdchk("status", 12'h104, PCUEL_VALID_BITS & 32'hFFFF_FFFE);
        bus(1'b1, 12'h104, 32'hFFFF_FFFF, dummy);
        rdchk("status", 12'h104, 32'h0);
        // Event lands in the clearing data phase: the set wins
        fork
            bus(1'b1, 12'h104, 32'h0000_4000, dummy);
            begin
                repeat (2) @(posedge hclk);
                err_event <= 21'h00_4000;
                @(posedge hclk);
                err_event <= '0;
            end
        join
        rdchk("status", 12'h104, 32'h0000_4000);
        $display("test write_clear done");
        bus(1'b1, 12'h108, 32'hFFFF_FFFF, dummy);
        rdchk("mask", 12'h108, PCUEL_VALID_BITS);
        pulse(21'h1F_FFFF, 21'h0);
        chk("err_status", PCUEL_VALID_BITS, {11'h0, err_status});
        chk("msg_count", 32'd12, msg_count);
        $display("test masking done");
        @(posedge hclk);
        hot_reset <= 1'b1;
        @(posedge hclk);
        hot_reset <= 1'b0;
        #1;
        chk("hrdata", 32'h0, hrdata);
        rdchk("status", 12'h104, PCUEL_VALID_BITS);
        rdchk("mask", 12'h108, PCUEL_VALID_BITS);
        $display("test hot_reset done");
        do_reset(1'b1);
        rdchk("next_link", 12'h100, next_dn);
        chk("strap", 32'h1, {31'h0, strap_seen});
        rdchk("status", 12'h104, 32'h0);
        rdchk("mask", 12'h108, 32'h0);
        $display("test power_reset done");
        finish_test();
    end
endmodule
`default_nettype wire
